// File: nvm_cfg.svh
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH
// serial instruction opcodes and second bytes
`define NVM_OP_RD_FUSE    8'h50
`define NVM_OP_RD_FHI     8'h58
`define NVM_OP_RD_SIG     8'h30
`define NVM_OP_RD_CAL     8'h38
`define NVM_OP_PAGE_WR    8'h4c
`define NVM_OP_EE_PAGE    8'hc2
`define NVM_OP_WRITE      8'hac
`define NVM_OP_POLL       8'hf0
`define NVM_B2_EXT        8'h08
`define NVM_B2_LOCK       8'he0
`define NVM_B2_FLO        8'ha0
`define NVM_B2_FHI        8'ha8
`define NVM_B2_FEXT       8'ha4
`define NVM_PAD           8'h00
// control register bit positions
`define NVM_CR_EN         0
`define NVM_CR_PGERS      1
`define NVM_CR_PGWRT      2
`define NVM_CR_LOCKSET    3
`define NVM_CR_RWWRE      4
`define NVM_CR_RWW_BUSY_FLAG      6
`define NVM_CR_IE         7
`define NVM_CR_LOCK_CMD   8'h09
`define NVM_CR_CMD_MASK   8'h7f
// reset values (all bits unprogrammed)
`define NVM_FUSE_RST      8'hff
`define NVM_LOCK_RST      8'hff
`define NVM_LOCK_MASK     8'h3f
// timing
`define NVM_SPM_WINDOW    3'd4
`define NVM_CLK_NS        50
`define NVM_WRITE_NS      4500
`define NVM_WRITE_CYC     ((`NVM_WRITE_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)
// host register offsets
`define NVM_R_SERCMD      8'h00
`define NVM_R_TPCMD       8'h04
`define NVM_R_STATUS      8'h08
`define NVM_R_SERRSP      8'h0c
`define NVM_R_TPRSP       8'h10
`endif

// File: nvm_pkg.sv
`default_nettype none
package nvm_pkg;
  // test-port programming instructions
  typedef enum logic [3:0] {
    TP_LOCK_EN  = 4'b0000,
    TP_LOCK_LD  = 4'b0001,
    TP_LOCK_WR  = 4'b0010,
    TP_LOCK_POL = 4'b0011,
    TP_FRD_EN   = 4'b0100,
    TP_FRD_HI   = 4'b0101,
    TP_FRD_LO   = 4'b0110,
    TP_FRD_LOCK = 4'b0111,
    TP_FRD_ALL  = 4'b1000,
    TP_SIG_EN   = 4'b1001,
    TP_SIG_ADR  = 4'b1010,
    TP_SIG_RD   = 4'b1011,
    TP_CAL_EN   = 4'b1100,
    TP_CAL_ADR  = 4'b1101,
    TP_CAL_RD   = 4'b1110
  } nvm_tp_instr_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SER  = 2'b01,
    H_POLL = 2'b10,
    H_TP   = 2'b11
  } nvm_host_state_t;
endpackage
`default_nettype wire

// File: nvm_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// serial byte link and test-port command link
interface nvm_link_if;
  logic                  serValid;
  logic [7:0]            serByte;
  logic                  serRspValid;
  logic [7:0]            serRsp;
  logic                  tpValid;
  nvm_pkg::nvm_tp_instr_t tpInstr;
  logic [7:0]            tpData;
  logic                  tpRspValid;
  logic [31:0]           tpRsp;
  modport dev  (input serValid, serByte, tpValid, tpInstr, tpData,
                output serRspValid, serRsp, tpRspValid, tpRsp);
  modport prog (output serValid, serByte, tpValid, tpInstr, tpData,
                input serRspValid, serRsp, tpRspValid, tpRsp);
endinterface
`default_nettype wire

// File: nvm_dev.sv
// What this block does
// RULE1: extended fuse read is 50 08 00, data
// RULE2: page write is 4C, address high, low, 00
// RULE3: eeprom page write is C2, address, 00
// RULE4: extended fuse write is AC A4 00 value
// RULE5: high fuse write is AC A8 00 value
// RULE6: poll LSB one while busy; wait
// RULE7: programmer loads low byte before high; nvm_prog has no page load and sends each command high byte first
// RULE8: zero is programmed, one unprogrammed
// RULE9: lock set needs store within four cycles
// RULE10: zero bits 5..0 program lock bits
// RULE11: pointer ignored during lock write
// RULE12: program memory readable during lock write
// RULE13: eeprom busy blocks programming and reads
// RULE14: page ops block section, busy flag set
// RULE15: software clears busy flag by reenable
// RULE16: interrupt requested while enable bit clear
// RULE17: halt for no-read-while-write page writes
// RULE18: test port lock write enable, load, write
// RULE19: test port zero bits program lock
// RULE20: test port fuse reads after enable
// RULE21: identity bytes read by address
// RULE22: calibration byte read at address zero
// RULE23: expired store window clears enable bits
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "nvm_cfg.svh"
module nvm_dev #(
  parameter logic [7:0]  SIG0      = 8'h11, // arbitrary
  parameter logic [7:0]  SIG1      = 8'h22, // arbitrary
  parameter logic [7:0]  SIG2      = 8'h33, // arbitrary
  parameter logic [7:0]  CAL       = 8'h80,
  parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_BASE = 16'h7000,
  parameter int          WRITE_CYC = `NVM_WRITE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  nvm_link_if.dev         link,
  input  wire logic       crWe,
  input  wire logic [7:0] crWdata,
  output logic      [7:0] crRdata,
  input  wire logic       storeExec,
  input  wire logic [7:0] workReg0,
  input  wire logic [15:0] zPtr,
  input  wire logic       eepromWriteBusy,
  input  wire logic       fuseRdReq,
  input  wire logic [1:0] fuseRdSel,
  output logic      [7:0] fuseRdData,
  output logic            fuseRdOk,
  output logic            rwwReadBlock,
  output logic            cpuHalt,
  output logic            storeIrq
);
  import nvm_pkg::*;

  typedef struct packed {
    logic [7:0]  cr;
    logic [2:0]  win;
    logic [15:0] busyCnt;
    logic        halt;
    logic [7:0]  fLo, fHi, fExt, lock;
    logic [1:0]  bCnt;
    logic [7:0]  b0, b1, b2;
    logic        sRv;
    logic [7:0]  sRsp;
    logic        lockEn, fEn, sigEn, calEn;
    logic [7:0]  tpLatch;
    logic [1:0]  sigAdr;
    logic        tRv;
    logic [31:0] tRsp;
    logic [7:0]  rdData;
    logic        rdOk;
  } nvm_dev_st_t;

  nvm_dev_st_t st_q, st_d;
  logic busy;
  logic [7:0] serRd;
  logic [7:0] sigSel;

  assign busy = st_q.busyCnt != 16'h0000;

  // identity byte chosen by the loaded address
  always_comb begin
    unique case (st_q.sigAdr)
      2'd0:    sigSel = SIG0;
      2'd1:    sigSel = SIG1;
      2'd2:    sigSel = SIG2;
      default: sigSel = 8'hff;
    endcase
  end

  // serial read data for the fourth byte
  always_comb begin
    serRd = 8'h00;
    if (st_q.b0 == `NVM_OP_POLL)
      serRd = {7'h00, busy}; // RULE6
    else if (st_q.b0 == `NVM_OP_RD_FUSE && st_q.b1 == `NVM_B2_EXT)
      serRd = st_q.fExt; // RULE1
    else if (st_q.b0 == `NVM_OP_RD_FUSE)
      serRd = st_q.fLo;
    else if (st_q.b0 == `NVM_OP_RD_FHI && st_q.b1 == `NVM_B2_EXT)
      serRd = st_q.fHi;
    else if (st_q.b0 == `NVM_OP_RD_FHI)
      serRd = st_q.lock;
    else if (st_q.b0 == `NVM_OP_RD_SIG)
      serRd = (st_q.b2[1:0] == 2'd0) ? SIG0 :
              (st_q.b2[1:0] == 2'd1) ? SIG1 : SIG2;
    else if (st_q.b0 == `NVM_OP_RD_CAL)
      serRd = CAL;
  end

  always_comb begin
    st_d = st_q;
    st_d.sRv = 1'b0;
    st_d.tRv = 1'b0;
    st_d.rdOk = 1'b0;
    // write timer; completion ends enable and releases a halt
    if (busy) begin
      st_d.busyCnt = st_q.busyCnt - 16'h0001;
      if (st_q.busyCnt == 16'h0001) begin
        st_d.halt = 1'b0; // RULE17
        st_d.cr[`NVM_CR_EN] = 1'b0;
        st_d.cr[`NVM_CR_PGERS] = 1'b0;
        st_d.cr[`NVM_CR_PGWRT] = 1'b0;
      end
    end
    // store window countdown
    if (st_q.win != 3'd0) begin
      st_d.win = st_q.win - 3'd1;
      if (st_q.win == 3'd1 && !busy) begin
        st_d.cr[`NVM_CR_EN] = 1'b0; // RULE23
        st_d.cr[`NVM_CR_LOCKSET] = 1'b0; // RULE23
        st_d.cr[`NVM_CR_RWWRE] = 1'b0;
      end
    end
    // control register write, refused during eeprom write
    if (crWe && !eepromWriteBusy && !busy) begin // RULE13
      st_d.cr[`NVM_CR_IE] = crWdata[`NVM_CR_IE];
      st_d.cr[5:0] = crWdata[5:0];
      st_d.win = crWdata[`NVM_CR_EN] ? `NVM_SPM_WINDOW : 3'd0; // RULE9
    end
    // store instruction inside the window
    // an eeprom write in progress blocks the store as well
    if (storeExec && st_q.win != 3'd0 && st_q.cr[`NVM_CR_EN] && !busy
        && !eepromWriteBusy) begin // RULE13
      st_d.win = 3'd0;
      if (st_q.cr[5:0] == `NVM_CR_LOCK_CMD) begin // RULE9
        // pointer not looked at; no section block
        st_d.lock = st_q.lock & (workReg0 | ~`NVM_LOCK_MASK); // RULE10 RULE11 RULE12
        st_d.busyCnt = 16'(WRITE_CYC);
      end else if (st_q.cr[`NVM_CR_RWWRE]) begin
        st_d.cr[`NVM_CR_RWW_BUSY_FLAG] = 1'b0; // RULE15
        st_d.cr[`NVM_CR_EN] = 1'b0;
        st_d.cr[`NVM_CR_RWWRE] = 1'b0;
      end else if (st_q.cr[`NVM_CR_PGERS] || st_q.cr[`NVM_CR_PGWRT]) begin
        st_d.busyCnt = 16'(WRITE_CYC);
        if (zPtr >= NO_READ_WHILE_WRITE_SECTION_BASE)
          st_d.halt = 1'b1; // RULE17
        else
          st_d.cr[`NVM_CR_RWW_BUSY_FLAG] = 1'b1; // RULE14
      end else
        st_d.cr[`NVM_CR_EN] = 1'b0;
    end
    // software fuse and lock reads
    if (fuseRdReq && !eepromWriteBusy) begin // RULE13
      st_d.rdOk = 1'b1;
      unique case (fuseRdSel)
        2'd0: st_d.rdData = st_q.fLo;
        2'd1: st_d.rdData = st_q.lock;
        2'd2: st_d.rdData = st_q.fExt;
        2'd3: st_d.rdData = st_q.fHi;
      endcase
    end
    // serial four-byte instructions
    if (link.serValid) begin
      st_d.sRv = 1'b1;
      st_d.sRsp = 8'h00;
      st_d.bCnt = st_q.bCnt + 2'd1;
      unique case (st_q.bCnt)
        2'd0: st_d.b0 = link.serByte;
        2'd1: st_d.b1 = link.serByte;
        2'd2: st_d.b2 = link.serByte;
        2'd3: begin
          st_d.sRsp = serRd; // RULE1 RULE6
          if (!busy && st_q.b0 == `NVM_OP_WRITE) begin
            st_d.busyCnt = 16'(WRITE_CYC);
            unique case (st_q.b1)
              `NVM_B2_FEXT: st_d.fExt = link.serByte; // RULE4 RULE8
              `NVM_B2_FHI:  st_d.fHi = link.serByte; // RULE5 RULE8
              `NVM_B2_FLO:  st_d.fLo = link.serByte;
              `NVM_B2_LOCK: st_d.lock = st_q.lock & link.serByte;
              default:      st_d.busyCnt = 16'h0000;
            endcase
          end else if (!busy && (st_q.b0 == `NVM_OP_PAGE_WR // RULE2
                                 || st_q.b0 == `NVM_OP_EE_PAGE)) // RULE3
            st_d.busyCnt = 16'(WRITE_CYC);
        end
      endcase
    end
    // test-port programming commands
    if (link.tpValid) begin
      st_d.tRv = 1'b1;
      st_d.tRsp = 32'h0;
      unique case (link.tpInstr)
        TP_LOCK_EN:  st_d.lockEn = 1'b1; // RULE18
        TP_LOCK_LD:  st_d.tpLatch = link.tpData;
        TP_LOCK_WR: if (st_q.lockEn && !busy) begin
          st_d.lock = st_q.lock & st_q.tpLatch; // RULE19
          st_d.busyCnt = 16'(WRITE_CYC);
          st_d.lockEn = 1'b0;
        end
        TP_LOCK_POL: st_d.tRsp = {31'h0, busy};
        TP_FRD_EN:   st_d.fEn = 1'b1; // RULE20
        TP_FRD_HI:   if (st_q.fEn) st_d.tRsp = {24'h0, st_q.fHi};
        TP_FRD_LO:   if (st_q.fEn) st_d.tRsp = {24'h0, st_q.fLo};
        TP_FRD_LOCK: if (st_q.fEn) st_d.tRsp = {24'h0, st_q.lock};
        TP_FRD_ALL:  if (st_q.fEn)
          st_d.tRsp = {st_q.fExt, st_q.fHi, st_q.fLo, st_q.lock};
        TP_SIG_EN:   st_d.sigEn = 1'b1; // RULE21
        TP_SIG_ADR:  st_d.sigAdr = link.tpData[1:0];
        TP_SIG_RD:   if (st_q.sigEn) st_d.tRsp = {24'h0, sigSel};
        TP_CAL_EN:   st_d.calEn = 1'b1; // RULE22
        TP_CAL_ADR:  st_d.sigAdr = link.tpData[1:0];
        TP_CAL_RD:   if (st_q.calEn) st_d.tRsp = {24'h0, CAL};
        default:     st_d.tRsp = 32'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.fLo <= `NVM_FUSE_RST; // RULE8
      st_q.fHi <= `NVM_FUSE_RST;
      st_q.fExt <= `NVM_FUSE_RST;
      st_q.lock <= `NVM_LOCK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign crRdata          = st_q.cr;
  assign rwwReadBlock     = st_q.cr[`NVM_CR_RWW_BUSY_FLAG]; // RULE14
  assign cpuHalt          = st_q.halt; // RULE17
  assign storeIrq = st_q.cr[`NVM_CR_IE] & ~st_q.cr[`NVM_CR_EN]; // RULE16
  assign fuseRdData       = st_q.rdData;
  assign fuseRdOk         = st_q.rdOk;
  assign link.serRspValid = st_q.sRv;
  assign link.serRsp      = st_q.sRsp;
  assign link.tpRspValid  = st_q.tRv;
  assign link.tpRsp       = st_q.tRsp;
endmodule
`default_nettype wire

// File: nvm_prog.sv
`timescale 1ns/1ns
`default_nettype none
`include "nvm_cfg.svh"
module nvm_prog (
  input  wire logic        clk,
  input  wire logic        rst,
  nvm_link_if.prog         link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  import nvm_pkg::*;

  typedef struct packed {
    nvm_host_state_t st;
    logic [31:0]     cmd;
    logic [1:0]      idx;
    logic            wait4;
    logic            isPoll;
    logic [7:0]      sRsp;
    logic [31:0]     tRsp;
    logic            ack;
    logic [31:0]     rd;
    logic            outV;
    logic [7:0]      outB;
    logic            tV;
    nvm_tp_instr_t   tI;
    logic [7:0]      tD;
  } nvm_host_st_t;

  nvm_host_st_t q, d;
  logic req;
  logic idle;
  logic [7:0] curB;
  logic isWr;

  assign req  = wb_cyc_i & wb_stb_i & ~q.ack;
  assign idle = q.st == H_IDLE;
  assign curB = q.isPoll ? (q.idx == 2'd0 ? `NVM_OP_POLL : `NVM_PAD)
                         : q.cmd[8*(3-q.idx) +: 8];
  assign isWr = q.cmd[31:24] == `NVM_OP_WRITE ||
                q.cmd[31:24] == `NVM_OP_PAGE_WR ||
                q.cmd[31:24] == `NVM_OP_EE_PAGE;

  always_comb begin
    d = q;
    d.ack = req;
    d.outV = 1'b0;
    d.tV = 1'b0;
    // register access, commands accepted only while idle
    if (req && wb_we_i && idle && wb_sel_i == 4'hf) begin
      if (wb_adr_i == `NVM_R_SERCMD) begin
        d.cmd = wb_dat_i; // RULE1 RULE2 RULE3 RULE4 RULE5
        d.st = H_SER;
        d.idx = 2'd0;
        d.wait4 = 1'b0;
        d.isPoll = 1'b0;
      end else if (wb_adr_i == `NVM_R_TPCMD) begin
        d.tV = 1'b1; // RULE18 RULE20 RULE21 RULE22
        d.tI = nvm_tp_instr_t'(wb_dat_i[11:8]);
        d.tD = wb_dat_i[7:0];
        d.st = H_TP;
      end
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `NVM_R_STATUS: d.rd = {31'h0, ~idle};
        `NVM_R_SERRSP: d.rd = {24'h0, q.sRsp};
        `NVM_R_TPRSP:  d.rd = q.tRsp;
        default:       d.rd = 32'h0;
      endcase
    end
    // serial byte sender: one byte, then wait for its reply
    if (q.st == H_SER || q.st == H_POLL) begin
      if (!q.wait4) begin
        d.outV = 1'b1;
        d.outB = curB;
        d.wait4 = 1'b1;
      end else if (link.serRspValid) begin
        d.wait4 = 1'b0;
        d.idx = q.idx + 2'd1;
        if (q.idx == 2'd3) begin
          if (q.isPoll) begin
            if (!link.serRsp[0]) d.st = H_IDLE; // RULE6
          end else begin
            d.sRsp = link.serRsp;
            d.isPoll = isWr;
            d.st = isWr ? H_POLL : H_IDLE; // RULE6
          end
        end
      end
    end
    if (q.st == H_TP && link.tpRspValid) begin
      d.tRsp = link.tpRsp;
      d.st = H_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o     = q.ack;
  assign wb_dat_o     = q.rd;
  assign link.serValid = q.outV;
  assign link.serByte  = q.outB;
  assign link.tpValid  = q.tV;
  assign link.tpInstr  = q.tI;
  assign link.tpData   = q.tD;
endmodule
`default_nettype wire

// File: nvm_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module nvm_link_properties #(
  parameter logic [7:0] SIG1 = 8'h22,
  parameter logic [7:0] CAL  = 8'h80
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   serValid,
  input wire logic [7:0]             serByte,
  input wire logic                   serRspValid,
  input wire logic [7:0]             serRsp,
  input wire logic                   tpValid,
  input wire nvm_pkg::nvm_tp_instr_t tpInstr,
  input wire logic [7:0]             tpData,
  input wire logic                   tpRspValid,
  input wire logic [31:0]            tpRsp
);
  import nvm_pkg::*;
  typedef struct packed {
    logic [1:0] idx;
    logic [7:0] op;
    logic       last;
    logic       pend;
    logic       frdEn;
    logic       sigEn;
    logic       calEn;
    logic [7:0] adr;
  } nvm_chk_t;
  nvm_chk_t s_q;
  nvm_chk_t s_d;
  // byte position, pending write and test-port enable tracking
  always_comb begin
    s_d = s_q;
    s_d.last = serValid && s_q.idx == 2'd3;
    if (serValid) begin
      s_d.idx = s_q.idx + 2'd1;
      if (s_q.idx == 2'd0) s_d.op = serByte;
      if (s_q.idx == 2'd0 && serByte inside {8'hac, 8'h4c, 8'hc2}) begin
        s_d.pend = 1'b1;
      end
    end
    if (serRspValid && s_q.last && s_q.op == 8'hf0 && !serRsp[0]) begin
      s_d.pend = 1'b0;
    end
    if (tpValid && (tpInstr == TP_SIG_EN || tpInstr == TP_CAL_EN)) begin
      s_d.sigEn = tpInstr == TP_SIG_EN;
      s_d.calEn = tpInstr == TP_CAL_EN;
    end
    if (tpValid && tpInstr == TP_FRD_EN) s_d.frdEn = 1'b1;
    if (tpValid && (tpInstr == TP_SIG_ADR || tpInstr == TP_CAL_ADR)) begin
      s_d.adr = tpData;
    end
  end
  // state register
  always_ff @(posedge clk) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence sigRead;
    tpValid && tpInstr == TP_SIG_RD && s_q.sigEn && s_q.adr == 8'h01;
  endsequence
  sequence calRead;
    tpValid && tpInstr == TP_CAL_RD && s_q.calEn && s_q.adr == 8'h00;
  endsequence
  ser_rsp_time_a:
    assert property (serValid |=> serRspValid)
    else $error("serial reply missing");
  ser_rsp_cause_a:
    assert property (serRspValid |-> $past(serValid) && !serValid)
    else $error("serial reply without byte");
  ser_pad_zero_a:
    assert property (serValid && s_q.idx != 2'd3 |=> serRsp == 8'h00)
    else $error("serial reply not zero");
  page_pad_a:
    assert property (serValid && s_q.idx == 2'd3
                     && s_q.op inside {8'h4c, 8'hc2} |-> serByte == 8'h00)
    else $error("page write last byte not zero");
  poll_gate_a:
    assert property (serValid && s_q.idx == 2'd0 && s_q.pend
                     |-> serByte == 8'hf0)
    else $error("instruction sent while busy");
  tp_rsp_time_a:
    assert property (tpValid |=> tpRspValid ##1 !tpRspValid)
    else $error("test port reply timing");
  tp_gate_a:
    assert property (tpValid && tpInstr == TP_FRD_HI && !s_q.frdEn
                     |=> tpRsp == 32'h0)
    else $error("fuse read without enable");
  sig_read_a:
    assert property (sigRead |=> tpRsp[7:0] == SIG1)
    else $error("identity byte wrong");
  cal_read_a:
    assert property (calRead |=> tpRsp[7:0] == CAL)
    else $error("calibration byte wrong");
endmodule
`default_nettype wire

// File: nvm_program_lock_fuse_access_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "nvm_cfg.svh"
module nvm_program_lock_fuse_access_tb;
  import nvm_pkg::*;
  localparam logic [7:0] SIG0 = 8'h1e; // arbitrary
  localparam logic [7:0] SIG1 = 8'h2d; // arbitrary
  localparam logic [7:0] SIG2 = 8'h3c; // arbitrary
  localparam logic [7:0] CAL  = 8'h6a; // arbitrary
  localparam logic [7:0] RS   = `NVM_R_SERCMD;
  localparam logic [7:0] RT   = `NVM_R_TPCMD;
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] cmd;
    logic [31:0] mask;
    logic [31:0] exp;
  } nvm_row_t;
  logic clk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00, crWdata = 8'h00, workReg0 = 8'hff;
  logic [3:0] wbSel = 4'hf;
  logic [31:0] wbDatW = 32'h0, wbDatR;
  logic wbAck, crWe = 1'b0, storeExec = 1'b0, eeBusy = 1'b0;
  logic fuseRdReq = 1'b0, fuseRdOk, rwwReadBlock, cpuHalt, storeIrq;
  logic [1:0] fuseRdSel = 2'd0;
  logic [15:0] zPtr = 16'h0001;
  logic [7:0] crRdata, fuseRdData;
  int failures = 0;
  int comparisons = 0;
  // instruction, register and expected reply for each ordinary case
  nvm_row_t rows [29] = '{
    '{RS, 32'h50080000, 32'hff, 32'hff},
    '{RS, 32'haca400f3, 32'h0, 32'h0},
    '{RS, 32'h50080000, 32'hff, 32'hf3},
    '{RS, 32'haca80055, 32'h0, 32'h0},
    '{RS, 32'h58080000, 32'hff, 32'h55},
    '{RS, 32'h30000100, 32'hff, {24'h0, SIG1}},
    '{RS, 32'h38000000, 32'hff, {24'h0, CAL}},
    '{RS, 32'h4c012300, 32'h0, 32'h0},
    '{RS, 32'hc2010400, 32'h0, 32'h0},
    '{RT, 32'h00000500, 32'hffffffff, 32'h0},
    '{RT, 32'h00000000, 32'h0, 32'h0},
    '{RT, 32'h000001fc, 32'h0, 32'h0},
    '{RT, 32'h00000200, 32'h0, 32'h0},
    '{RT, 32'h00000300, 32'h0, 32'h0},
    '{RT, 32'h00000400, 32'h0, 32'h0},
    '{RT, 32'h00000500, 32'hff, 32'h55},
    '{RT, 32'h00000600, 32'hff, 32'hff},
    '{RT, 32'h00000700, 32'hff, 32'hfc},
    '{RT, 32'h00000800, 32'hffffffff, 32'hf355fffc},
    '{RT, 32'h00000900, 32'h0, 32'h0},
    '{RT, 32'h00000a00, 32'h0, 32'h0},
    '{RT, 32'h00000b00, 32'hff, {24'h0, SIG0}},
    '{RT, 32'h00000a01, 32'h0, 32'h0},
    '{RT, 32'h00000b00, 32'hff, {24'h0, SIG1}},
    '{RT, 32'h00000a02, 32'h0, 32'h0},
    '{RT, 32'h00000b00, 32'hff, {24'h0, SIG2}},
    '{RT, 32'h00000c00, 32'h0, 32'h0},
    '{RT, 32'h00000d00, 32'h0, 32'h0},
    '{RT, 32'h00000e00, 32'hff, {24'h0, CAL}}
  };
  nvm_link_if nvm_link_if_inst ();
  nvm_dev #(.SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2), .CAL(CAL),
            .WRITE_CYC(4)) nvm_dev_inst (
    .clk(clk), .rst(rst), .link(nvm_link_if_inst), .crWe(crWe),
    .crWdata(crWdata), .crRdata(crRdata), .storeExec(storeExec),
    .workReg0(workReg0), .zPtr(zPtr), .eepromWriteBusy(eeBusy),
    .fuseRdReq(fuseRdReq), .fuseRdSel(fuseRdSel),
    .fuseRdData(fuseRdData), .fuseRdOk(fuseRdOk),
    .rwwReadBlock(rwwReadBlock), .cpuHalt(cpuHalt), .storeIrq(storeIrq));
  nvm_prog nvm_prog_inst (
    .clk(clk), .rst(rst), .link(nvm_link_if_inst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck));
  nvm_link_properties #(.SIG1(SIG1), .CAL(CAL)) nvm_link_properties_inst (
    .clk(clk), .rst(rst), .serValid(nvm_link_if_inst.serValid),
    .serByte(nvm_link_if_inst.serByte), .tpData(nvm_link_if_inst.tpData),
    .serRspValid(nvm_link_if_inst.serRspValid),
    .serRsp(nvm_link_if_inst.serRsp), .tpValid(nvm_link_if_inst.tpValid),
    .tpInstr(nvm_link_if_inst.tpInstr), .tpRsp(nvm_link_if_inst.tpRsp),
    .tpRspValid(nvm_link_if_inst.tpRspValid));
  // system clock
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatR;
    if (n == 50) failures++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk);
  endtask
  // issue a command, wait for idle, fetch the reply
  task automatic run(input nvm_row_t r, output logic [31:0] rsp);
    logic [31:0] st;
    int n;
    n = 0;
    wb(1'b1, r.adr, r.cmd, st);
    do begin
      wb(1'b0, `NVM_R_STATUS, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 200);
    if (n == 200) failures++;
    wb(1'b0, r.adr == RS ? `NVM_R_SERRSP : `NVM_R_TPRSP, 32'h0, rsp);
  endtask
  task automatic cr(input logic [7:0] d);
    crWe <= 1'b1;
    crWdata <= d;
    @(posedge clk);
    crWe <= 1'b0;
    @(posedge clk);
  endtask
  task automatic store_program_instruction;
    storeExec <= 1'b1;
    @(posedge clk);
    storeExec <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fuse_rd(input logic [1:0] sel, output logic [8:0] okData);
    fuseRdReq <= 1'b1;
    fuseRdSel <= sel;
    @(posedge clk);
    fuseRdReq <= 1'b0;
    @(posedge clk);
    okData = {fuseRdOk, fuseRdData};
  endtask
  // main sequence
  initial begin
    logic [31:0] got;
    logic [8:0] fd;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      run(rows[i], got);
      chk(got & rows[i].mask, rows[i].exp, "row");
    end
    run('{RS, 32'h58000000, 32'hff, 32'h0}, got);
    chk(got & 32'hff, 32'hfc, "serial lock");
    wb(1'b0, 8'h20, 32'h0, got);
    chk(got, 32'h0, "unmapped");
    $display("test rows done");
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({24'h0, crRdata}, 32'h0, "cr reset");
    fuse_rd(2'd3, fd);
    chk({23'h0, fd}, 32'h1ff, "fuse reset");
    $display("test reset done");
    cr(8'h80);
    @(posedge clk);
    chk_flag(storeIrq, 1'b1, "irq on");
    cr(8'h81);
    @(posedge clk);
    chk_flag(storeIrq, 1'b0, "irq off");
    repeat (4) @(posedge clk);
    chk({23'h0, storeIrq, crRdata}, 32'h180, "expired");
    $display("test window done");
    workReg0 <= 8'h35;
    cr(8'h09);
    store_program_instruction();
    repeat (6) begin
      chk_flag(rwwReadBlock | cpuHalt, 1'b0, "lock busy");
      @(posedge clk);
    end
    fuse_rd(2'd1, fd);
    chk({23'h0, fd}, 32'h1f5, "cpu lock");
    $display("test lock done");
    eeBusy <= 1'b1;
    cr(8'h05);
    chk_flag(crRdata[0], 1'b0, "ee block cr");
    fuse_rd(2'd1, fd);
    chk_flag(fd[8], 1'b0, "ee block read");
    eeBusy <= 1'b0;
    $display("test eeprom done");
    zPtr <= 16'h0100;
    cr(8'h05);
    store_program_instruction();
    repeat (10) @(posedge clk);
    chk({29'h0, cpuHalt, rwwReadBlock, crRdata[6]}, 32'h3, "rww");
    cr(8'h11);
    store_program_instruction();
    repeat (2) @(posedge clk);
    chk_flag(rwwReadBlock, 1'b0, "reenable");
    zPtr <= 16'h7000;
    cr(8'h05);
    store_program_instruction();
    chk_flag(cpuHalt, 1'b1, "halt");
    repeat (10) @(posedge clk);
    chk_flag(cpuHalt | rwwReadBlock, 1'b0, "halt end");
    $display("test page done");
    test_done();
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
